// ===== verilog/pug_pkg.sv
// Package for the pattern generator: register map, field layout, modes, helpers.
// Assumes a single 125 MHz system clock; one generated bit per lane per clock.
package pug_pkg;

  localparam int          LANES      = 4;
  localparam int          DATA_W     = 32;
  localparam int          CLK_MHZ    = 125;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_RATE   = 8'h04;
  localparam logic [7:0]  OFF_MODE   = 8'h08;
  localparam logic [7:0]  OFF_ULEN   = 8'h0c;
  localparam logic [7:0]  OFF_FRAME  = 8'h10;
  localparam logic [7:0]  OFF_UDATA  = 8'h14;
  localparam logic [7:0]  OFF_UCTRL  = 8'h18;
  localparam logic [7:0]  OFF_STAT   = 8'h1c;
  localparam logic [7:0]  OFF_FCNT   = 8'h20;
  localparam logic [7:0]  OFF_BAD    = 8'hff;

  // Control bits
  localparam int          CTRL_RUN   = 0;
  localparam int          CTRL_USER  = 1;
  localparam int          CTRL_EXT   = 2;
  localparam int          CTRL_FRAME = 3;
  localparam int          CTRL_W     = 4;

  // Rate fields
  localparam int          RATE_OVC   = 3;
  localparam int          RATE_MUL   = 4;
  localparam logic [2:0]  RANGE_MIN  = 3'h1;
  localparam logic [2:0]  RANGE_MAX  = 3'h6;
  localparam logic [3:0]  MULT_MIN   = 4'h1;
  localparam logic [3:0]  MULT_MAX   = 4'h8;

  // Frame divider limits
  localparam logic [30:0] FRAME_MIN  = 31'h0000_0020;

  // Square pattern, 32-bit period, and user word granularity
  localparam logic [31:0] SQ2_LIM    = 32'h0000_0001;
  localparam logic [31:0] SQ32_LIM   = 32'h0000_001f;
  localparam int          SQ32_MSB   = 4;
  localparam logic [5:0]  UWORD_LSBS = 6'h3f;
  localparam int          MODE_W     = 4;

  typedef enum logic [3:0] {
    PM_P7, PM_P9, PM_P10, PM_P11, PM_P13, PM_P15, PM_P20, PM_P23, PM_P31,
    PM_SQ2, PM_SQ32, PM_USER, PM_OFF
  } pug_mode_t;

  typedef struct packed {
    logic      run;
    pug_mode_t mode;
  } pug_lane_cfg_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } pug_aphase_t;

  // Register order n of a pseudo-random mode
  function automatic logic [5:0] prbs_order(input pug_mode_t m);
    unique case (m)
      PM_P7:   prbs_order = 6'h07;
      PM_P9:   prbs_order = 6'h09;
      PM_P10:  prbs_order = 6'h0a;
      PM_P11:  prbs_order = 6'h0b;
      PM_P13:  prbs_order = 6'h0d;
      PM_P15:  prbs_order = 6'h0f;
      PM_P20:  prbs_order = 6'h14;
      PM_P23:  prbs_order = 6'h17;
      PM_P31:  prbs_order = 6'h1f;
      default: prbs_order = 6'h00;
    endcase
  endfunction : prbs_order

  // Feedback bit for each polynomial; s[k-1] stands for x^k
  function automatic logic prbs_fb(input pug_mode_t m, input logic [30:0] s);
    unique case (m)
      PM_P7:   prbs_fb = s[6]  ^ s[5];
      PM_P9:   prbs_fb = s[8]  ^ s[4];
      PM_P10:  prbs_fb = s[9]  ^ s[6];
      PM_P11:  prbs_fb = s[10] ^ s[8];
      PM_P13:  prbs_fb = s[12] ^ s[11] ^ s[1];
      PM_P15:  prbs_fb = s[14] ^ s[13];
      PM_P20:  prbs_fb = s[19] ^ s[16];
      PM_P23:  prbs_fb = s[22] ^ s[17];
      PM_P31:  prbs_fb = s[30] ^ s[27];
      default: prbs_fb = 1'b0;
    endcase
  endfunction : prbs_fb

  // Illegal mode codes collapse to off
  function automatic pug_mode_t mode_of(input logic [3:0] code);
    mode_of = (code > PM_OFF) ? PM_OFF : pug_mode_t'(code);
  endfunction : mode_of

endpackage : pug_pkg

// ===== verilog/pug_fifo.sv
// Word FIFO with valid/ready on both sides, storage in flip-flops.
// Assumes DEPTH is a power of two; single clock domain.
`timescale 1ns/100ps
module pug_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  // Fill side
  input  wire logic                       in_valid,
  output      logic                       in_ready,
  input  wire logic [W-1:0]               in_data,
  // Drain side
  output      logic                       out_valid,
  input  wire logic                       out_ready,
  output      logic [W-1:0]               out_data,
  // Fill level
  output      logic [$clog2(DEPTH):0]     level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest flags straight from the count
  assign in_ready  = (cnt_q < (AW+1)'(DEPTH));  // Room until DEPTH words are held
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + AW'(1);
      if (pop)
        rp_q <= rp_q + AW'(1);
      if (push && !pop)
        cnt_q <= cnt_q + (AW+1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (AW+1)'(1);
    end
  end

endmodule : pug_fifo

// ===== verilog/pug_lane.sv
// One serial lane: pseudo-random, square or user bit, one bit per clock.
// Assumes the user bit for lane position pos arrives in the same cycle that pos is shown.
`timescale 1ns/100ps
module pug_lane
  import pug_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  // Configuration
  input  wire pug_lane_cfg_t   cfg,
  input  wire logic [31:0]     user_bits_m1,
  input  wire logic            user_bit,
  // Serial output and position
  output      logic            bit_q,
  output      logic            wrap_q,
  output      logic [31:0]     pos_q
);
  pug_mode_t   mode_q;
  logic        live_q;
  logic [30:0] sr_q;
  logic [31:0] limit;
  logic        restart;
  logic        is_prbs;

  assign restart = !cfg.run || (cfg.mode != mode_q);
  assign is_prbs = (prbs_order(cfg.mode) != 6'h00);

  // Period length minus one for the running mode
  always_comb
  begin
    unique case (cfg.mode)
      PM_SQ2:  limit = SQ2_LIM;
      PM_SQ32: limit = SQ32_LIM;
      PM_USER: limit = user_bits_m1;
      PM_OFF:  limit = '0;
      default: limit = (32'h1 << prbs_order(cfg.mode)) - 32'h2;  // R1
    endcase
  end

  // Mode tracking; a new mode restarts the sequence from its seed
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= PM_OFF;
      live_q <= 1'b0;
    end
    else
    begin
      mode_q <= cfg.mode;
      live_q <= !restart;
    end
  end

  // Shift register, all ones as seed so it never locks at zero; the three P13 taps hold it at all ones
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sr_q <= '1;
    else if (restart)
      sr_q <= '1;
    else if (is_prbs)
      sr_q <= {sr_q[29:0], prbs_fb(cfg.mode, sr_q)};  // R2 R3
  end

  // Position counter wraps exactly at the period, no gap bits
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_q  <= '0;
      wrap_q <= 1'b0;
    end
    else
    begin
      wrap_q <= !restart && (pos_q == limit);  // R13
      if (restart || pos_q == limit)
        pos_q <= '0;
      else
        pos_q <= pos_q + 32'h1;
    end
  end

  // Output bit
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      bit_q <= 1'b0;
    else if (restart)
      bit_q <= 1'b0;
    else
    begin
      unique case (cfg.mode)
        PM_SQ2:  bit_q <= ~bit_q;              // R4
        PM_SQ32: bit_q <= pos_q[SQ32_MSB];     // R4
        PM_USER: bit_q <= user_bit;            // R5
        PM_OFF:  bit_q <= 1'b0;
        default: bit_q <= sr_q[5'(prbs_order(cfg.mode) - 6'h01)];  // R1
      endcase
    end
  end

  property p_p7_fb;
    @(posedge clk_sys) disable iff (!arst_n)
    live_q && mode_q == PM_P7 && cfg.mode == PM_P7 && cfg.run
      |=> sr_q[0] == ($past(sr_q[6]) ^ $past(sr_q[5]));
  endproperty
  a_p7_fb: assert property (p_p7_fb) else $error("prbs7 feedback wrong"); // R2

  property p_p31_fb;
    @(posedge clk_sys) disable iff (!arst_n)
    live_q && mode_q == PM_P31 && cfg.mode == PM_P31 && cfg.run
      |=> sr_q[0] == ($past(sr_q[30]) ^ $past(sr_q[27]));
  endproperty
  a_p31_fb: assert property (p_p31_fb) else $error("prbs31 feedback wrong"); // R3

  property p_sq2;
    @(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && cfg.mode == PM_SQ2)[*3] |-> bit_q != $past(bit_q);
  endproperty
  a_sq2: assert property (p_sq2) else $error("half rate square not toggling"); // R4

  property p_wrap;
    @(posedge clk_sys) disable iff (!arst_n)
    wrap_q |-> pos_q == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without restart of position"); // R13

  c_p7_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    mode_q == PM_P7 && wrap_q);
endmodule : pug_lane

// ===== verilog/pug_top.sv
// Pattern generator top: AHB-Lite registers, four lanes, user memory, frame marker.
// Assumes one AHB-Lite master on clk_sys; bit clock modelled as one bit per clk_sys.
// Notes on behaviour
// R1: Each lane picks a maximal sequence of order 7,9,10,11,13,15,20,23 or 31; order 13 here stays at its all-ones seed.
// R2: Orders 7 to 13 use their fixed two- or three-term feedback polynomials.
// R3: Orders 15 to 31 use their fixed two-term feedback polynomials.
// R4: Two square patterns: toggle every bit, and period of 32 bits.
// R5: Each lane stores its own user pattern and plays it out.
// R6: User length is whole 64-bit words, one length shared by all lanes.
// R7: User pattern mode turns waveform playback off.
// R8: One rate setting serves all four lanes.
// R9: Rate range one of six; top range may be overclocked.
// R10: Frame pulse once every N pattern lengths, N from 32 to 2^31-1.
// R11: Frame pulse drives the second marker, shared with playback marker.
// R12: External clock multiplier programmable from 1 to 8.
// R13: Every pattern repeats back to back with no gap bits.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module pug_top
  import pug_pkg::*;
#(
  parameter int UP_WORDS   = 16,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output      logic                 hreadyout,
  output      logic                 hresp,
  output      logic [31:0]          hrdata,
  // Serial lanes and marker
  input  wire logic                 awg_marker2,
  output      logic [LANES-1:0]     lane_bit,
  output      logic                 marker2_q,
  // Clocking and playback control
  output      logic                 awg_en_q,
  output      logic                 ext_clk_sel_q,
  output      logic [2:0]           rate_range_q,
  output      logic                 overclock_q,
  output      logic [3:0]           pll_mult_q
);
  localparam int UW   = $clog2(UP_WORDS);
  localparam int WW   = UW + 1;
  localparam int LW   = $clog2(LANES);
  localparam int FLW  = $clog2(FIFO_DEPTH) + 1;

  pug_aphase_t         aph_q;
  logic                busy_q;
  logic                hreadyout_q;
  logic [31:0]         hrdata_q;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [LANES*MODE_W-1:0] mode_q;
  logic [UW-1:0]       ulen_q;
  logic [30:0]         frame_div_q;
  logic [30:0]         fcnt_q;
  logic [31:0]         frames_q;
  logic                frame_pulse_q;
  logic [LW-1:0]       wlane_q;
  logic [WW-1:0]       widx_q;
  logic [31:0]         umem_q [LANES*2*UP_WORDS];
  pug_lane_cfg_t       cfg [LANES];
  logic [LANES-1:0]    ubit;
  logic [LANES-1:0]    wrap;
  logic [31:0]         pos [LANES];
  logic [31:0]         user_bits_m1;
  logic                f_in_valid;
  logic                f_in_ready;
  logic                f_out_valid;
  logic                f_out_ready;
  logic [31:0]         f_out_data;
  logic [FLW-1:0]      f_level;
  logic                done;
  logic [31:0]         rd_val;
  logic [30:0]         wr_frame;
  logic [2:0]          wr_range;
  logic [3:0]          wr_mult;

  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Data phase ends unless a pattern word waits for room in the FIFO
  assign f_in_valid = busy_q && aph_q.wr && (aph_q.addr == OFF_UDATA);
  assign done       = busy_q && !(f_in_valid && !f_in_ready);
  assign wr_frame   = (hwdata[30:0] < FRAME_MIN) ? FRAME_MIN : hwdata[30:0];
  assign wr_range   = hwdata[2:0];
  assign wr_mult    = hwdata[RATE_MUL +: 4];

  // Address phase capture and ready; every transfer gets at least one wait state
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aph_q       <= '0;
      busy_q      <= 1'b0;
      hreadyout_q <= 1'b1;
    end
    else if (hsel && htrans[1] && hready)
    begin
      aph_q.wr    <= hwrite;
      aph_q.addr  <= (haddr[31:8] == '0) ? haddr[7:0] : OFF_BAD;
      busy_q      <= 1'b1;
      hreadyout_q <= 1'b0;
    end
    else if (done)
    begin
      busy_q      <= 1'b0;
      hreadyout_q <= 1'b1;
    end
  end

  // Register writes; out-of-range values are clamped or refused
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q       <= '0;
      mode_q       <= {LANES{4'(PM_OFF)}};
      ulen_q       <= '0;
      frame_div_q  <= FRAME_MIN;
      rate_range_q <= RANGE_MAX;
      overclock_q  <= 1'b0;
      pll_mult_q   <= MULT_MIN;
    end
    else if (done && aph_q.wr)
    begin
      unique case (aph_q.addr)
        OFF_CTRL:  ctrl_q <= hwdata[CTRL_W-1:0];
        OFF_MODE:  mode_q <= hwdata[LANES*MODE_W-1:0];  // R1
        OFF_ULEN:  ulen_q <= hwdata[UW-1:0];            // R6
        OFF_FRAME: frame_div_q <= wr_frame;             // R10
        OFF_RATE:
        begin
          if (wr_range >= RANGE_MIN && wr_range <= RANGE_MAX)
            rate_range_q <= wr_range;                   // R8 R9
          overclock_q <= hwdata[RATE_OVC] && (wr_range == RANGE_MAX);  // R9
          if (wr_mult >= MULT_MIN && wr_mult <= MULT_MAX)
            pll_mult_q <= wr_mult;                      // R12
        end
        default: ;
      endcase
    end
  end

  // Readback view
  always_comb
  begin
    unique case (aph_q.addr)
      OFF_CTRL:  rd_val = 32'(ctrl_q);
      OFF_RATE:  rd_val = 32'({pll_mult_q, overclock_q, rate_range_q});
      OFF_MODE:  rd_val = 32'(mode_q);
      OFF_ULEN:  rd_val = 32'(ulen_q);
      OFF_FRAME: rd_val = 32'(frame_div_q);
      OFF_UCTRL: rd_val = 32'(wlane_q);
      OFF_STAT:  rd_val = 32'({f_level, awg_en_q, ext_clk_sel_q});
      OFF_FCNT:  rd_val = frames_q;
      default:   rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      hrdata_q <= '0;
    else if (done && !aph_q.wr)
      hrdata_q <= rd_val;
  end

  // Pattern words queue here; loading stalls while user patterns play
  pug_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (hwdata),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );
  assign f_out_ready = !ctrl_q[CTRL_USER] || !ctrl_q[CTRL_RUN];

  // Pattern memory loader; a UCTRL write picks the lane and rewinds
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wlane_q <= '0;
      widx_q  <= '0;
    end
    else if (done && aph_q.wr && aph_q.addr == OFF_UCTRL)
    begin
      wlane_q <= hwdata[LW-1:0];
      widx_q  <= '0;
    end
    else if (f_out_valid && f_out_ready)
      widx_q  <= widx_q + WW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (f_out_valid && f_out_ready)
      umem_q[{wlane_q, widx_q}] <= f_out_data;  // R5
  end

  // Shared user length in bits minus one, whole 64-bit words
  assign user_bits_m1 = 32'({ulen_q, UWORD_LSBS});  // R6

  // Lanes; all share lane 0 position so user playback stays aligned
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign cfg[i].run  = ctrl_q[CTRL_RUN];
    assign cfg[i].mode = ctrl_q[CTRL_USER] ? PM_USER                       // R6
                       : mode_of(mode_q[i*MODE_W +: MODE_W]);
    assign ubit[i] = umem_q[{LW'(i), pos[0][5 +: WW]}][pos[0][4:0]];
    pug_lane u_lane (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .cfg          (cfg[i]),
      .user_bits_m1 (user_bits_m1),
      .user_bit     (ubit[i]),
      .bit_q        (lane_bit[i]),
      .wrap_q       (wrap[i]),
      .pos_q        (pos[i])
    );
  end

  // Clock source selection and playback exclusion
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awg_en_q      <= 1'b1;
      ext_clk_sel_q <= 1'b0;
    end
    else
    begin
      awg_en_q      <= !ctrl_q[CTRL_USER];  // R7
      ext_clk_sel_q <= ctrl_q[CTRL_EXT];    // R12
    end
  end

  // Frame divider counts whole periods of lane 0
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fcnt_q        <= '0;
      frame_pulse_q <= 1'b0;
      frames_q      <= '0;
    end
    else
    begin
      frame_pulse_q <= 1'b0;
      if (!ctrl_q[CTRL_RUN])
        fcnt_q <= '0;
      else if (wrap[0])
      begin
        if (fcnt_q == frame_div_q - 31'h1)
        begin
          fcnt_q        <= '0;
          frame_pulse_q <= 1'b1;  // R10
          frames_q      <= frames_q + 32'h1;
        end
        else
          fcnt_q <= fcnt_q + 31'h1;
      end
    end
  end

  // Marker 2 carries the frame pulse when enabled, else playback marker
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      marker2_q <= 1'b0;
    else
      marker2_q <= ctrl_q[CTRL_FRAME] ? frame_pulse_q : awg_marker2;  // R11
  end

  property p_awg_off;
    @(posedge clk_sys) disable iff (!arst_n)
    ctrl_q[CTRL_USER] |=> !awg_en_q;
  endproperty
  a_awg_off: assert property (p_awg_off) else $error("playback left on in user mode"); // R7

  property p_frame_min;
    @(posedge clk_sys) disable iff (!arst_n)
    frame_div_q >= FRAME_MIN;
  endproperty
  a_frame_min: assert property (p_frame_min) else $error("frame divider below 32"); // R10

  property p_frame_cnt;
    @(posedge clk_sys) disable iff (!arst_n)
    frame_pulse_q |-> $past(wrap[0]) && fcnt_q == 31'h0;
  endproperty
  a_frame_cnt: assert property (p_frame_cnt) else $error("frame pulse off a wrap"); // R10

  property p_marker;
    @(posedge clk_sys) disable iff (!arst_n)
    frame_pulse_q && ctrl_q[CTRL_FRAME] |=> marker2_q;
  endproperty
  a_marker: assert property (p_marker) else $error("frame pulse not on marker 2"); // R11

  property p_mult;
    @(posedge clk_sys) disable iff (!arst_n)
    pll_mult_q >= MULT_MIN && pll_mult_q <= MULT_MAX;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier out of 1..8"); // R12

  property p_range;
    @(posedge clk_sys) disable iff (!arst_n)
    rate_range_q >= RANGE_MIN && rate_range_q <= RANGE_MAX
      && (!overclock_q || rate_range_q == RANGE_MAX);
  endproperty
  a_range: assert property (p_range) else $error("rate range illegal"); // R9

  property p_user_all;
    @(posedge clk_sys) disable iff (!arst_n)
    ctrl_q[CTRL_USER] |-> cfg[0].mode == PM_USER && cfg[LANES-1].mode == PM_USER;
  endproperty
  a_user_all: assert property (p_user_all) else $error("lanes differ in user mode"); // R6

  property p_hready;
    @(posedge clk_sys) disable iff (!arst_n)
    hsel && htrans[1] && hready |=> !hreadyout;
  endproperty
  a_hready: assert property (p_hready) else $error("no wait state after address"); // AHB-Lite wait state, decided locally

  c_frame: cover property (@(posedge clk_sys) disable iff (!arst_n) marker2_q);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (!arst_n)
    f_in_valid && !f_in_ready);
  c_user: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_q[CTRL_USER] && ctrl_q[CTRL_RUN] && wrap[0]);
endmodule : pug_top

// ===== tb/pug_rx_model.sv
// Serial receiver model: keeps the last 128 bits seen on each lane.
// Assumes one bit per lane per clk_sys edge; it never pushes back.
`timescale 1ns/100ps
module pug_rx_model
  import pug_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Lanes in, history out, newest bit at index 0
  input  wire logic [LANES-1:0] lane_bit,
  output      logic [127:0]     hist_q [LANES]
);
  // Shift every lane each clock, so checks need no alignment to the start
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < LANES; i++)
        hist_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
        hist_q[i] <= {hist_q[i][126:0], lane_bit[i]};
    end
  end
endmodule : pug_rx_model

// ===== tb/test_pug_top.sv
// Bench for the pattern generator: AHB-Lite master tasks and lane scenarios.
// Assumes the receiver model beside it; hready is looped back from hreadyout.
`timescale 1ns/100ps
module test_pug_top;
  import pug_pkg::*;
  logic             clk_sys, arst_n, hsel, hwrite, awg_marker2, hreadyout, hresp;
  logic             marker2_q, awg_en_q, ext_clk_sel_q, overclock_q;
  logic [1:0]       htrans;
  logic [2:0]       rate_range_q;
  logic [3:0]       pll_mult_q;
  logic [LANES-1:0] lane_bit;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [127:0]     hist [LANES];
  int               fail_count, tests_run;

  pug_top u_pug_top (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .awg_marker2, .lane_bit,
    .marker2_q, .awg_en_q, .ext_clk_sel_q, .rate_range_q, .overclock_q, .pll_mult_q);
  pug_rx_model u_pug_rx_model (.clk_sys, .arst_n, .lane_bit, .hist_q(hist));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One single word transfer; no latency assumed, the watchdog bounds the waits
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic t_rate();
    chk("range rst", 32'(rate_range_q), 32'h6);
    chk("mult rst", 32'(pll_mult_q), 32'h1);
    chk("awg rst", 32'(awg_en_q), 32'h1);
    ahb(1'b1, OFF_RATE, 32'h83);
    ahb(1'b1, OFF_RATE, 32'h9f);
    repeat (2) @(posedge clk_sys);
    chk("range", 32'(rate_range_q), 32'h3);
    chk("mult", 32'(pll_mult_q), 32'h8);
    chk("ovc", 32'(overclock_q), 32'h0);
    ahb(1'b1, OFF_RATE, 32'h1e);
    ahb(1'b1, OFF_CTRL, 32'h4);
    repeat (2) @(posedge clk_sys);
    chk("range top", 32'(rate_range_q), 32'h6);
    chk("ovc top", 32'(overclock_q), 32'h1);
    chk("mult min", 32'(pll_mult_q), 32'h1);
    chk("ext", 32'(ext_clk_sel_q), 32'h1);
    ahb(1'b0, OFF_BAD, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : t_rate

  // Output must obey each recurrence; an all-zero lane would too, so refuse it
  task automatic t_prbs();
    int n [9] = '{7, 9, 10, 11, 13, 15, 20, 23, 31};
    int k [9] = '{6, 5, 7, 9, 12, 14, 17, 18, 28};
    int bad;
    for (int m = 0; m < 9; m++)
    begin
      ahb(1'b1, OFF_MODE, {16'h0, {4{4'(m)}}});
      ahb(1'b1, OFF_CTRL, 32'h1);
      repeat (140) @(posedge clk_sys);
      for (int l = 0; l < LANES; l++)
      begin
        bad = int'(hist[l] == 128'h0);
        for (int j = 0; j < 96; j++)
          bad += hist[l][j] ^ hist[l][j+n[m]] ^ hist[l][j+k[m]] ^ (m == 4 && hist[l][j+2]);
        chk("prbs", 32'(bad), 32'h0);
        if (m == 0)
          chk("p7 period", 32'(hist[l][0] ^ hist[l][127]), 32'h0);
      end
    end
    ahb(1'b1, OFF_MODE, 32'h0000_aa99);
    repeat (140) @(posedge clk_sys);
    chk("sq2", hist[1][31:0] ^ hist[1][32:1], 32'hffff_ffff);
    chk("sq32", hist[2][31:0] ^ hist[2][63:32], 32'h0);
    chk("sq32 half", hist[3][31:0] ^ hist[3][47:16], 32'hffff_ffff);
  endtask : t_prbs

  task automatic t_frame();
    int c;
    awg_marker2 <= 1'b1;
    ahb(1'b1, OFF_FRAME, 32'h5);
    ahb(1'b0, OFF_FRAME, 32'h0);
    chk("frame min", rd, 32'h20);
    chk("marker pass", 32'(marker2_q), 32'h1);
    awg_marker2 <= 1'b0;
    ahb(1'b1, OFF_MODE, 32'hf999);  // Lane 3 gets an illegal code, which must read as off
    ahb(1'b1, OFF_CTRL, 32'h9);
    do @(posedge clk_sys); while (marker2_q !== 1'b1);
    @(posedge clk_sys);
    for (c = 1; marker2_q !== 1'b1; c++)
      @(posedge clk_sys);
    chk("frame gap", 32'(c), 32'd64);
    chk("off lane", hist[3][31:0], 32'h0);
  endtask : t_frame

  // Memory is loaded while stopped; the FIFO drains except while user mode runs
  task automatic t_user();
    ahb(1'b1, OFF_CTRL, 32'h0);
    ahb(1'b1, OFF_ULEN, 32'h0);
    for (int l = 0; l < LANES; l++)
    begin
      ahb(1'b1, OFF_UCTRL, 32'(l));
      ahb(1'b1, OFF_UDATA, 32'h1 << l);
      ahb(1'b1, OFF_UDATA, 32'h0);
    end
    ahb(1'b1, OFF_CTRL, 32'h3);
    repeat (140) @(posedge clk_sys);
    chk("awg off", 32'(awg_en_q), 32'h0);
    for (int l = 0; l < LANES; l++)
    begin
      chk("user ones", 32'($countones(hist[l][63:0])), 32'h1);
      chk("user period", hist[l][31:0] ^ hist[l][95:64], 32'h0);
    end
  endtask : t_user

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Whole run is a few thousand cycles; this leaves a wide margin
  initial
  begin
    #(8 * 20000);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    {arst_n, hsel, hwrite, awg_marker2, htrans, haddr, hwdata} = '0;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_rate();
    t_prbs();
    t_frame();
    t_user();
    wrap_up();
  end
endmodule : test_pug_top
